/* pem_pkg.sv */
// Constants, register indices and carrier types of the power event monitor
// Assumes a 125 MHz clock_i and an AXI4-Lite master with 32-bit data
package pem_pkg;
  localparam int CLK_NS = 8;                 // Clock period in ns
  localparam int TICK_NS_DEF = 10000;        // Default timebase tick in ns
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_MODE  = 8'h52;
  localparam logic [7:0] IDX_MATCH = 8'h54;
  localparam logic [7:0] IDX_MASK  = 8'h55;
  localparam logic [7:0] IDX_SEL   = 8'h56;
  localparam logic [7:0] IDX_LED   = 8'h57;
  localparam logic [7:0] IDX_STAT  = 8'h58;
  localparam logic [7:0] IDX_RETRY = 8'h59;
  localparam logic [7:0] IDX_T3EN  = 8'h5a;
  localparam logic [7:0] IDX_T3CTL = 8'h5b;
  localparam logic [7:0] IDX_T4EN  = 8'h5c;
  localparam logic [7:0] IDX_T4CTL = 8'h5d;
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_DEC  = 2'h3;
  // Field positions
  localparam int SEL_EN = 7, SEL_MEM = 6, SEL_WR = 5, SEL_RD = 4;
  localparam int LED_QUICK = 4, RT_IGN4 = 6, RT_EN = 5, RT_STOPEN = 2;
  localparam int TC_EN = 3, TC_SPC = 2, TC_IO = 1, TC_MST = 0;
  localparam int MD_SWSMI = 7, MD_REL = 6, MD_HALT = 5, MD_UNHALT = 4;
  localparam int MD_SLOW = 3, MD_UNSLOW = 2, MD_SUSDIS = 1, MD_PDEN = 0;
  // Times in microseconds
  localparam longint LED_US [4] = '{400000, 1000000, 1800000, 3500000};
  localparam longint QUICK_US = 3000000;
  localparam longint RETRY_US [4] = '{55000, 200, 1000000, 3500000};
  localparam longint STOP_US [4] = '{430, 860, 1700, 7000};
  localparam longint TMR_US [16] = '{1000000, 1800000, 3500000, 7000000,
    14000000, 28000000, 56000000, 120000000, 228000000, 450000000,
    900000000, 1800000000, 64'hd693_a400, 64'h1_ad27_4800,
    64'h3_5a4e_9000, 64'h6_b49d_2000};
  localparam logic [3:0] T3_UNDEF = 4'hd;   // Timer 3 code without a time
  localparam logic [3:0] T4_UNDEF = 4'he;   // Timer 4 code without a time
  // Observed CPU bus cycle
  typedef struct packed {
    logic        valid;
    logic        io;
    logic        write;
    logic [31:0] addr;
  } pem_cycle_t;
  // Halt sequencer states
  typedef enum logic [2:0] {
    HS_RUN   = 3'b001,
    HS_DELAY = 3'b010,
    HS_HALT  = 3'b100
  } pem_halt_t;
endpackage : pem_pkg

/* pem_top.sv */
// Power event monitor: event timers, SYSTEM_MGMT_IRQ_OUT, halt and slow clock control
// Assumes AXI4-Lite master on clock_i and event inputs synchronous pulses
//
// Our own choice: the AXI4-Lite slave port.
module pem_top #(
  parameter int TICK_NS = pem_pkg::TICK_NS_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic [8:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [8:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire pem_pkg::pem_cycle_t cycle_i,
  input  wire logic [7:0]        event_src_i,
  input  wire logic              io_event_i,
  input  wire logic              master_event_i,
  input  wire logic              standby_start_i,
  input  wire logic              standby_end_i,
  input  wire logic              suspend_tc_i,
  input  wire logic              quick_powerdown_in_i,
  output logic                   system_mgmt_irq_out_o,
  output logic                   cpu_clock_halt_out_o,
  output logic                   cpu_clock_slow_out_o,
  output logic                   powerdown_led_o
);
  localparam int TICK_CYC = TICK_NS / pem_pkg::CLK_NS;

  // Converts microseconds to ticks, never below one
  function automatic logic [31:0] us2t(input longint us);
    longint t;
    t = us * 1000 / TICK_NS;
    // Saturates so the longest periods never wrap at a fine tick
    return (t < 1) ? 32'h1 : (t > 64'hffff_ffff) ? 32'hffff_ffff : 32'(t);
  endfunction

  logic [7:0] reg_mode, reg_match, reg_mask, reg_sel, reg_led, reg_retry;
  logic [7:0] reg_t3en, reg_t3ctl, reg_t4en, reg_t4ctl;
  logic       stat_set_b;
  logic [7:0] stat_a;
  logic       susp_mode, susp_tc, powerdown, system_mgmt_irq_out, smi_gap;
  logic       tick;
  logic [15:0] tick_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       aw_held, w_held;
  logic [7:0] aw_idx;
  logic [7:0] w_byte;
  logic       w_lane;
  logic       wr_go;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic       rd_hit;

  assign wr_go  = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_idx = aw_idx;
  assign rd_idx = {1'b0, s_axi_araddr_i[8:2]};

  // Address and data captured independently
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 8'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_idx  <= {1'b0, s_axi_awaddr_i[8:2]};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata_i[7:0];
        w_lane <= s_axi_wstrb_i[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready offered while nothing is held
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  // Known write indices
  function automatic logic known(input logic [7:0] i);
    return (i == pem_pkg::IDX_MODE) ||
           (i >= pem_pkg::IDX_MATCH && i <= pem_pkg::IDX_T4CTL);
  endfunction

  // Write response
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= pem_pkg::RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= known(wr_idx) ? pem_pkg::RESP_OK : pem_pkg::RESP_DEC;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Register writes, low byte lane only
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reg_mode  <= pem_pkg::RST_REG;
      reg_match <= pem_pkg::RST_REG;
      reg_mask  <= pem_pkg::RST_REG;
      reg_sel   <= pem_pkg::RST_REG;
      reg_led   <= pem_pkg::RST_REG;
      reg_retry <= pem_pkg::RST_REG;
      reg_t3en  <= pem_pkg::RST_REG;
      reg_t3ctl <= pem_pkg::RST_REG;
      reg_t4en  <= pem_pkg::RST_REG;
      reg_t4ctl <= pem_pkg::RST_REG;
      stat_set_b <= 1'b0;
    end else if (wr_go && w_lane) begin
      unique case (wr_idx)
        pem_pkg::IDX_MODE:  reg_mode  <= w_byte;
        pem_pkg::IDX_MATCH: reg_match <= w_byte;
        pem_pkg::IDX_MASK:  reg_mask  <= w_byte;
        pem_pkg::IDX_SEL:   reg_sel   <= w_byte;
        pem_pkg::IDX_LED:   reg_led   <= w_byte & 8'h70;
        pem_pkg::IDX_STAT:  stat_set_b <= w_byte[7];
        pem_pkg::IDX_RETRY: reg_retry <= w_byte & 8'h7f;
        pem_pkg::IDX_T3EN:  reg_t3en  <= w_byte;
        pem_pkg::IDX_T3CTL: reg_t3ctl <= w_byte;
        pem_pkg::IDX_T4EN:  reg_t4en  <= w_byte;
        pem_pkg::IDX_T4CTL: reg_t4ctl <= w_byte;
        default: ;
      endcase
    end
  end

  // Read mux; status register shows the selected set
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      pem_pkg::IDX_MODE:  rd_val = reg_mode;
      pem_pkg::IDX_MATCH: rd_val = reg_match;
      pem_pkg::IDX_MASK:  rd_val = reg_mask;
      pem_pkg::IDX_SEL:   rd_val = reg_sel;
      pem_pkg::IDX_LED:   rd_val = reg_led;
      pem_pkg::IDX_STAT:  rd_val = stat_set_b ?
        {2'h0, powerdown, susp_mode, cpu_clock_halt_out_o,
         cpu_clock_slow_out_o, susp_tc, system_mgmt_irq_out_o} : stat_a;
      pem_pkg::IDX_RETRY: rd_val = reg_retry;
      pem_pkg::IDX_T3EN:  rd_val = reg_t3en;
      pem_pkg::IDX_T3CTL: rd_val = reg_t3ctl;
      pem_pkg::IDX_T4EN:  rd_val = reg_t4en;
      pem_pkg::IDX_T4CTL: rd_val = reg_t4ctl;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= pem_pkg::RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {24'h0, rd_val};
      s_axi_rresp_o   <= rd_hit ? pem_pkg::RESP_OK : pem_pkg::RESP_DEC;
    end else if (s_axi_rvalid_o) begin
      s_axi_rvalid_o  <= !s_axi_rready_i;
      s_axi_arready_o <= s_axi_rready_i;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase tick
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 16'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYC - 1)) ? 16'h0 : tick_cnt + 16'h1;
    end
  end

  // Special address detection
  logic [7:0] mem_bits;
  logic       spc_hit, dir_ok, addr_ok;
  assign mem_bits = {cycle_i.addr[31], cycle_i.addr[26:20]};
  assign dir_ok = (cycle_i.write && reg_sel[pem_pkg::SEL_WR]) ||
                  (!cycle_i.write && reg_sel[pem_pkg::SEL_RD]);
  assign addr_ok = reg_sel[pem_pkg::SEL_MEM] ?
    (((mem_bits ^ reg_match) & ~reg_mask) == 8'h00) :
    (cycle_i.addr[19:0] == {reg_sel[3:0], reg_mask, reg_match});
  assign spc_hit = cycle_i.valid && reg_sel[pem_pkg::SEL_EN] &&
                   (cycle_i.io != reg_sel[pem_pkg::SEL_MEM]) &&
                   dir_ok && addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Inactivity timers 3 and 4
  logic [1:0]  t_evt_rst, t_expire;
  logic [31:0] t_cnt [2];
  logic [7:0]  t_en [2];
  logic [7:0]  t_ctl [2];
  logic [3:0]  t_undef [2];
  assign t_en[0]  = reg_t3en;
  assign t_en[1]  = reg_t4en;
  assign t_ctl[0] = reg_t3ctl;
  assign t_ctl[1] = reg_t4ctl;
  assign t_undef[0] = pem_pkg::T3_UNDEF;
  assign t_undef[1] = pem_pkg::T4_UNDEF;

  for (genvar g = 0; g < 2; g++) begin : g_tmr
    logic        ev, ign;
    logic [31:0] lim;
    assign ign = (g == 1) && reg_retry[pem_pkg::RT_IGN4];
    assign ev = |(event_src_i & t_en[g]) ||
                (t_ctl[g][pem_pkg::TC_SPC] && spc_hit) ||
                (t_ctl[g][pem_pkg::TC_IO] && io_event_i) ||
                (t_ctl[g][pem_pkg::TC_MST] && master_event_i);
    assign lim = (t_ctl[g][7:4] == t_undef[g]) ? 32'h0 :
                 us2t(pem_pkg::TMR_US[t_ctl[g][7:4]]);
    // Count ticks, restart on events, pulse at terminal count
    always_ff @(posedge clock_i) begin
      if (!reset_n_i || !t_ctl[g][pem_pkg::TC_EN]) begin
        t_cnt[g]     <= 32'h0;
        t_evt_rst[g] <= 1'b0;
        t_expire[g]  <= 1'b0;
      end else begin
        t_evt_rst[g] <= ev && !ign;
        t_expire[g]  <= 1'b0;
        if (ev && !ign) begin
          t_cnt[g] <= 32'h0;
        end else if (tick && lim != 32'h0) begin
          if (t_cnt[g] == lim - 32'h1) begin
            t_cnt[g]    <= 32'h0;
            t_expire[g] <= 1'b1;
          end else begin
            t_cnt[g] <= t_cnt[g] + 32'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SYSTEM_MGMT_IRQ_OUT causes, SYSTEM_MGMT_IRQ_OUT line and retry
  logic        smi_set, smi_rel;
  logic [31:0] retry_cnt;
  logic        retry_fire;
  assign smi_set = |t_evt_rst || |t_expire || standby_start_i ||
                   standby_end_i || suspend_tc_i ||
                   reg_mode[pem_pkg::MD_SWSMI];
  assign smi_rel = reg_mode[pem_pkg::MD_REL];
  assign retry_fire = reg_retry[pem_pkg::RT_EN] && system_mgmt_irq_out && tick &&
    (retry_cnt == us2t(pem_pkg::RETRY_US[reg_retry[4:3]]) - 32'h1);

  // Sticky causes, cleared by release unless a cause arrives together
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stat_a <= 8'h00;
    end else begin
      stat_a <= (smi_rel ? 8'h00 : stat_a) | {standby_start_i,
        standby_end_i, suspend_tc_i, reg_mode[pem_pkg::MD_SWSMI],
        t_expire[0], t_evt_rst[0], t_expire[1], t_evt_rst[1]};
    end
  end

  // SYSTEM_MGMT_IRQ_OUT held until released; set wins
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      system_mgmt_irq_out <= 1'b0;
    end else if (smi_set) begin
      system_mgmt_irq_out <= 1'b1;
    end else if (smi_rel) begin
      system_mgmt_irq_out <= 1'b0;
    end
  end

  // Retry timer drops the line one cycle to form a new SYSTEM_MGMT_IRQ_OUT
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !system_mgmt_irq_out || !reg_retry[pem_pkg::RT_EN]) begin
      retry_cnt <= 32'h0;
      smi_gap   <= 1'b0;
    end else begin
      smi_gap <= retry_fire;
      if (retry_fire) begin
        retry_cnt <= 32'h0;
      end else if (tick) begin
        retry_cnt <= retry_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      system_mgmt_irq_out_o <= 1'b0;
    end else begin
      system_mgmt_irq_out_o <= (system_mgmt_irq_out || smi_set) && !retry_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quick power-down and suspend flags
  logic        any_evt;
  logic [31:0] quick_cnt;
  assign any_evt = |event_src_i || spc_hit || io_event_i || master_event_i;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      quick_cnt <= 32'h0;
      powerdown <= 1'b0;
    end else if (any_evt || !reg_led[pem_pkg::LED_QUICK] ||
                 !quick_powerdown_in_i) begin
      quick_cnt <= 32'h0;
      powerdown <= 1'b0;
    end else if (tick && !powerdown) begin
      if (quick_cnt == us2t(pem_pkg::QUICK_US) - 32'h1) begin
        powerdown <= 1'b1;
      end else begin
        quick_cnt <= quick_cnt + 32'h1;
      end
    end
  end

  // Suspend mode and suspend terminal count flags
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      susp_mode <= 1'b0;
      susp_tc   <= 1'b0;
    end else begin
      if (suspend_tc_i) begin
        susp_mode <= 1'b1;
      end else if (any_evt || !reg_mode[pem_pkg::MD_PDEN]) begin
        susp_mode <= 1'b0;
      end
      if (suspend_tc_i) begin
        susp_tc <= 1'b1;
      end else if (reg_mode[pem_pkg::MD_SUSDIS]) begin
        susp_tc <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halt sequencer with optional delay, slow clock control
  pem_pkg::pem_halt_t hstate;
  logic [15:0] halt_cnt;
  logic [15:0] halt_lim;
  assign halt_lim = 16'(us2t(pem_pkg::STOP_US[reg_retry[1:0]]));

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || reg_mode[pem_pkg::MD_UNHALT]) begin
      hstate   <= pem_pkg::HS_RUN;
      halt_cnt <= 16'h0;
    end else begin
      unique case (hstate)
        pem_pkg::HS_RUN: begin
          halt_cnt <= 16'h0;
          if (reg_mode[pem_pkg::MD_HALT]) begin
            hstate <= (reg_mode[pem_pkg::MD_PDEN] &&
                       reg_retry[pem_pkg::RT_STOPEN]) ?
                      pem_pkg::HS_DELAY : pem_pkg::HS_HALT;
          end
        end
        pem_pkg::HS_DELAY: begin
          if (tick) begin
            halt_cnt <= halt_cnt + 16'h1;
            if (halt_cnt == halt_lim - 16'h1) begin
              hstate <= pem_pkg::HS_HALT;
            end
          end
        end
        pem_pkg::HS_HALT: hstate <= pem_pkg::HS_HALT;
        default: hstate <= pem_pkg::HS_RUN;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cpu_clock_halt_out_o <= 1'b0;
      cpu_clock_slow_out_o <= 1'b0;
    end else begin
      cpu_clock_halt_out_o <= (hstate == pem_pkg::HS_HALT);
      if (reg_mode[pem_pkg::MD_UNSLOW]) begin
        cpu_clock_slow_out_o <= 1'b0;
      end else if (reg_mode[pem_pkg::MD_SLOW]) begin
        cpu_clock_slow_out_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down LED flashes while powered down
  logic [31:0] led_cnt;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !powerdown) begin
      led_cnt         <= 32'h0;
      powerdown_led_o <= 1'b0;
    end else if (tick) begin
      if (led_cnt == us2t(pem_pkg::LED_US[reg_led[6:5]]) - 32'h1) begin
        led_cnt         <= 32'h0;
        powerdown_led_o <= !powerdown_led_o;
      end else begin
        led_cnt <= led_cnt + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  hit_io_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (spc_hit && !reg_sel[pem_pkg::SEL_MEM]) |->
      cycle_i.addr[19:0] == {reg_sel[3:0], reg_mask, reg_match})
    else $error("I/O hit without full address match");
  hit_dir_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    spc_hit |-> (cycle_i.write ? reg_sel[5] : reg_sel[4]))
    else $error("Hit in a direction not enabled");
  hit_en_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !reg_sel[7] |-> !spc_hit)
    else $error("Hit while detection disabled");
  smi_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (system_mgmt_irq_out_o && !smi_rel && !smi_gap && !retry_fire) |=>
      system_mgmt_irq_out_o || $past(retry_fire))
    else $error("SYSTEM_MGMT_IRQ_OUT dropped without release");
  smi_cause_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(t_expire[0]) |=> system_mgmt_irq_out_o && stat_a[3])
    else $error("Timer 3 expiry did not raise SYSTEM_MGMT_IRQ_OUT");
  stat_sel_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (wr_go && w_lane && wr_idx == pem_pkg::IDX_STAT) |=>
      stat_set_b == $past(w_byte[7]))
    else $error("Status set select not latched");
  ign_t4_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    reg_retry[6] |-> ##1 !t_evt_rst[1])
    else $error("Timer 4 restarted while ignoring events");
  halt_run_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (hstate == pem_pkg::HS_DELAY) |-> !cpu_clock_halt_out_o ##1 1'b1)
    else $error("Halt asserted during delay");
  led_off_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !powerdown ##1 !powerdown |-> !powerdown_led_o)
    else $error("LED active outside power-down");
  susp_tc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    suspend_tc_i |=> susp_tc && susp_mode)
    else $error("Suspend flags not set");
endmodule // pem_top

/* pem_cpu_model.sv */
// CPU bus cycle source standing in for the processor
// Assumes go_i comes from the bench, one bus cycle per request
module pem_cpu_model (
  input  wire logic           clock_i,
  input  wire logic           go_i,
  input  wire logic           io_i,
  input  wire logic           write_i,
  input  wire logic [31:0]    addr_i,
  output pem_pkg::pem_cycle_t cycle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus starts clear
  initial cycle_o = '0;
  // One valid cycle per request; idle address flips so it never lingers
  always @(posedge clock_i) begin
    if (go_i) begin
      cycle_o <= {1'b1, io_i, write_i, addr_i};
    end else begin
      cycle_o <= {1'b0, cycle_o.io, cycle_o.write, ~cycle_o.addr};
    end
  end
endmodule // pem_cpu_model

/* tb_top.sv */
// Bench: register access, SYSTEM_MGMT_IRQ_OUT causes, event timers, address match
// Assumes pem_top on AXI4-Lite and the CPU cycle model beside it
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, awv, wv, bry, arv, rry, go, gio, gwr;
  logic        awr, wrr, bv, arr, rv, system_mgmt_irq_out, halt, slow, led;
  logic [8:0]  awa, ara;
  logic [7:0]  ev, i;
  logic [4:0]  xe;
  logic [31:0] wd, gad, rdat, rdo;
  logic [1:0]  rsp, bresp, rresp;
  pem_pkg::pem_cycle_t cyc;
  int          fails, comparisons, tick;
  pem_cpu_model CPU (.clock_i(clk), .go_i(go), .io_i(gio), .write_i(gwr),
    .addr_i(gad), .cycle_o(cyc));
  pem_top #(.TICK_NS(800)) DUT (.clock_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .cycle_i(cyc),
    .event_src_i(ev), .io_event_i(xe[0]), .master_event_i(xe[1]),
    .standby_start_i(xe[2]), .standby_end_i(xe[3]), .suspend_tc_i(xe[4]),
    .quick_powerdown_in_i(1'b0), .system_mgmt_irq_out_o(system_mgmt_irq_out),
    .cpu_clock_halt_out_o(halt), .cpu_clock_slow_out_o(slow),
    .powerdown_led_o(led));
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 5000) begin
      fails++;
      close_out;
    end
  end
  task close_out;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bus write, each channel released once taken
  task wr(input logic [7:0] x, d, input logic [1:0] e = 2'h0);
    logic a, w;
    a = 1;
    w = 1;
    @(posedge clk);
    awa <= {x[6:0], 2'h0};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      if (a && awr) begin a = 0; awv <= 0; end
      if (w && wrr) begin w = 0; wv <= 0; end
    end while (!bv);
    bry <= 0;
    chk(bresp, e);
  endtask
  // Bus read and compare
  task rchk(input logic [7:0] x, input logic [31:0] e, logic [1:0] r = 0);
    logic a;
    a = 1;
    @(posedge clk);
    ara <= {x[6:0], 2'h0};
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      if (a && arr) begin a = 0; arv <= 0; end
    end while (!rv);
    rdat = rdo;
    rsp = rresp;
    rry <= 0;
    chk(rdat, e);
    chk(rsp, r);
  endtask
  task pulse(input logic [7:0] s, input logic [4:0] x);
    @(posedge clk);
    ev <= s;
    xe <= x;
    @(posedge clk);
    ev <= 0;
    xe <= 0;
    repeat (4) @(posedge clk);
  endtask
  task cpu(input logic io, w, input logic [31:0] a);
    @(posedge clk);
    {go, gio, gwr, gad} <= {1'b1, io, w, a};
    @(posedge clk);
    go <= 0;
    repeat (5) @(posedge clk);
  endtask
  task rel;
    wr(pem_pkg::IDX_MODE, 8'h40);
    wr(pem_pkg::IDX_MODE, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awv, wv, bry, arv, rry, go, gio, gwr, rst_n} = '0;
    {awa, ara, ev, xe, wd, gad, fails, comparisons, tick} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (i = 8'h54; i < 8'h5e; i++) begin
      if (i != 8'h58) begin
        rchk(i, 0);
        wr(i, 8'h5a);
        rchk(i, (i == pem_pkg::IDX_LED) ? 32'h50 : 32'h5a);
        wr(i, 8'h00);
      end
    end
    rchk(8'h00, 0, 2'h3);
    wr(8'h00, 8'h11, 2'h3);
    wr(pem_pkg::IDX_MODE, 8'h80);
    wr(pem_pkg::IDX_MODE, 8'h00);
    chk(system_mgmt_irq_out, 1);
    wr(pem_pkg::IDX_STAT, 8'h80);
    rchk(pem_pkg::IDX_STAT, 32'h01);
    wr(pem_pkg::IDX_STAT, 8'h00);
    rchk(pem_pkg::IDX_STAT, 32'h10);
    rel;
    chk(system_mgmt_irq_out, 0);
    wr(pem_pkg::IDX_T3EN, 8'h80);
    wr(pem_pkg::IDX_T3CTL, 8'h0a);
    pulse(8'h40, 5'h00);
    chk(system_mgmt_irq_out, 0);
    pulse(8'h80, 5'h00);
    chk(system_mgmt_irq_out, 1);
    rchk(pem_pkg::IDX_STAT, 32'h04);
    rel;
    pulse(8'h00, 5'h01);
    chk(system_mgmt_irq_out, 1);
    rel;
    wr(pem_pkg::IDX_MATCH, 8'h81);
    wr(pem_pkg::IDX_SEL, 8'he0);
    wr(pem_pkg::IDX_T3CTL, 8'h0c);
    cpu(0, 0, 32'h981f_ffff);
    chk(system_mgmt_irq_out, 0);
    cpu(0, 1, 32'h8000_0000);
    chk(system_mgmt_irq_out, 0);
    wr(pem_pkg::IDX_MASK, 8'h01);
    cpu(0, 1, 32'h8000_0000);
    chk(system_mgmt_irq_out, 1);
    rel;
    wr(pem_pkg::IDX_SEL, 8'hb1);
    wr(pem_pkg::IDX_MATCH, 8'h34);
    cpu(1, 1, 32'h0001_0134);
    chk(system_mgmt_irq_out, 1);
    rel;
    wr(pem_pkg::IDX_T3CTL, 8'h00);
    wr(pem_pkg::IDX_T4EN, 8'h01);
    wr(pem_pkg::IDX_T4CTL, 8'h08);
    wr(pem_pkg::IDX_RETRY, 8'h40);
    pulse(8'h01, 5'h00);
    chk(system_mgmt_irq_out, 0);
    wr(pem_pkg::IDX_RETRY, 8'h00);
    pulse(8'h01, 5'h00);
    rchk(pem_pkg::IDX_STAT, 32'h01);
    rel;
    chk(led, 0);
    wr(pem_pkg::IDX_MODE, 8'h28);
    wr(pem_pkg::IDX_STAT, 8'h80);
    chk(halt, 1);
    chk(slow, 1);
    rchk(pem_pkg::IDX_STAT, 32'h0c);
    wr(pem_pkg::IDX_MODE, 8'h14);
    wr(pem_pkg::IDX_RETRY, 8'h04);
    chk(halt, 0);
    chk(slow, 0);
    wr(pem_pkg::IDX_MODE, 8'h21);
    rchk(pem_pkg::IDX_STAT, 32'h00);
    close_out;
  end
endmodule // tb_top
